// File: logic/cbr_bridge_regs.sv
// Bridge control words and subsystem vendor word of a two-socket bridge.
// Assumes cfg from same-clock host bus logic; card pins are asynchronous.
//
// Function
// - Bits 15 to 11 of the bridge control word read zero, writes ignored.
// - Bit 10 enables burst write posting, one copy per socket.
// - Bit 9 marks memory window 1 prefetchable, resets to 1, per socket.
// - Bit 8 marks memory window 0 prefetchable, resets to 1.
// - Bit 7 routes card interrupts: 0 to PCI outputs, 1 to legacy IRQ.
// - Bit 6 drives card reset while set; resets to 1.
// - Host bus reset also asserts card reset regardless of bit 6.
// - Bit 6 survives host bus reset; only global reset restores it.
// - Bit 5 set makes card master aborts signal target abort and SERR.
// - Bit 5 is one copy shared by both sockets; either function writes it.
// - Bit 4 reads zero and ignores writes.
// - Bit 3 set forwards VGA memory accesses, and VGA I/O accesses while bit 2 is clear, to the card.
// - Bit 2 set blocks last 768 bytes of each 1K ISA I/O block.
// - Bit 1 set forwards card system error to PCI SERR, per socket.
// - Bit 0 set reports card parity errors on parity error pin.
// - Subsystem vendor word writable only while subsys_write_en is 0.
// - Subsystem vendor word sits at offset 40h in functions 0 and 1.
// - Bridge control word at offset 3Eh, reset value 0340h.
`timescale 1ns/1ps
module cbr_bridge_regs
    import cbr_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic hostBusResetN,
    input wire cbr_cfg_s cfg,
    input wire logic subsysWriteEn,
    input wire logic serrEnable,
    input wire logic [1:0] cardIrqIn,
    input wire logic [1:0] cardSysErrIn,
    input wire logic [1:0] parityErrSeen,
    input wire logic [1:0] masterAbortSeen,
    input wire logic accValid,
    input wire logic accSocket,
    input wire logic accIsIo,
    input wire logic [31:0] accAddr,
    output logic [15:0] rdData_ff,
    output logic rdValid_ff,
    output logic [1:0] cardResetN_ff,
    output cbr_sock_s [1:0] sockCtl_ff,
    output logic [1:0] pciIrq_ff,
    output logic [1:0] legacyIrq_ff,
    output logic pciSerr_ff,
    output logic targetAbort_ff,
    output logic [1:0] cardParityErr_ff,
    output logic accForward_ff,
    output logic accDone_ff
);
    logic [15:0] ctl_ff [2];
    logic mabtReport_ff;
    logic [15:0] svid_ff;
    logic hostRstMeta_ff;
    logic hostRst_ff;
    logic [1:0] irqMeta_ff;
    logic [1:0] irqSync_ff;
    logic [1:0] serrMeta_ff;
    logic [1:0] serrSync_ff;
    logic [15:0] nxt_rdData;
    logic [15:0] beMask;

    // Byte-lane merge of write data into a word under a bit mask
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [15:0] m);
        merge = (old & ~m) | (wd & m);
    endfunction

    // True when an address falls inside a closed range
    function automatic logic inRange(input logic [31:0] a,
                                     input logic [31:0] lo,
                                     input logic [31:0] hi);
        inRange = (a >= lo) && (a <= hi);
    endfunction

    assign beMask = {{8{cfg.be[1]}}, {8{cfg.be[0]}}};

    // Two-stage synchronisers for pins
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hostRstMeta_ff <= 1'b1;
            hostRst_ff <= 1'b1;
            irqMeta_ff <= 2'h0;
            irqSync_ff <= 2'h0;
            serrMeta_ff <= 2'h0;
            serrSync_ff <= 2'h0;
        end
        else
        begin
            hostRstMeta_ff <= ~hostBusResetN;
            hostRst_ff <= hostRstMeta_ff;
            irqMeta_ff <= cardIrqIn;
            irqSync_ff <= irqMeta_ff;
            serrMeta_ff <= cardSysErrIn;
            serrSync_ff <= serrMeta_ff;
        end
    end

    // Per-socket bridge control words, one per function
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctl_ff[0] <= CBR_CTL_RESET;
            ctl_ff[1] <= CBR_CTL_RESET;
        end
        else
        begin
            for (int s = 0; s < 2; s++)
            begin
                if (hostRst_ff)
                begin
                    // Host reset reloads reset values into all but card reset control
                    ctl_ff[s] <= (CBR_CTL_RESET & CBR_CTL_SOCKET_MASK &
                        ~(16'h0001 << CBR_BIT_CARD_RESET)) |
                        (ctl_ff[s] & (16'h0001 << CBR_BIT_CARD_RESET));
                end
                else if (cfg.wr && cfg.func == s[0] &&
                         cfg.addr[7:1] == CBR_OFS_BRIDGE_CTL[7:1])
                begin
                    // Only socket bits change; 15:11 and 4 stay zero
                    ctl_ff[s] <= merge(ctl_ff[s], cfg.wdata,
                        beMask & CBR_CTL_SOCKET_MASK);
                end
            end
        end
    end

    // Shared master abort report bit, written from either function
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            mabtReport_ff <= CBR_CTL_RESET[CBR_BIT_MABT_REPORT];
        else if (hostRst_ff)
            mabtReport_ff <= CBR_CTL_RESET[CBR_BIT_MABT_REPORT];
        else if (cfg.wr && cfg.be[0] &&
                 cfg.addr[7:1] == CBR_OFS_BRIDGE_CTL[7:1])
            mabtReport_ff <= cfg.wdata[CBR_BIT_MABT_REPORT];
    end

    // Subsystem vendor word, shared by both functions
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            svid_ff <= CBR_SVID_RESET;
        else if (cfg.wr && !subsysWriteEn &&
                 cfg.addr[7:1] == CBR_OFS_SUBSYS_VENDOR[7:1])
            svid_ff <= merge(svid_ff, cfg.wdata, beMask);
    end

    // Read data mux
    always_comb
    begin
        nxt_rdData = 16'h0000;
        if (cfg.addr[7:1] == CBR_OFS_BRIDGE_CTL[7:1])
        begin
            nxt_rdData = ctl_ff[cfg.func] & CBR_CTL_SOCKET_MASK;
            nxt_rdData[CBR_BIT_MABT_REPORT] = mabtReport_ff;
        end
        else if (cfg.addr[7:1] == CBR_OFS_SUBSYS_VENDOR[7:1])
            nxt_rdData = svid_ff;
    end

    // Registered read answer, one cycle after the request
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdData_ff <= 16'h0000;
            rdValid_ff <= 1'b0;
        end
        else
        begin
            rdValid_ff <= cfg.rd;
            if (cfg.rd)
                rdData_ff <= nxt_rdData;
        end
    end

    // Card side outputs per socket
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cardResetN_ff <= 2'h0;
            sockCtl_ff <= '0;
            pciIrq_ff <= 2'h0;
            legacyIrq_ff <= 2'h0;
            cardParityErr_ff <= 2'h0;
        end
        else
        begin
            for (int s = 0; s < 2; s++)
            begin
                cardResetN_ff[s] <= ~(ctl_ff[s][CBR_BIT_CARD_RESET] |
                    hostRst_ff);
                sockCtl_ff[s].posting <= ctl_ff[s][CBR_BIT_POSTING];
                sockCtl_ff[s].win1Pf <= ctl_ff[s][CBR_BIT_WIN1_PF];
                sockCtl_ff[s].win0Pf <= ctl_ff[s][CBR_BIT_WIN0_PF];
                sockCtl_ff[s].vgaFwd <= ctl_ff[s][CBR_BIT_VGA_FWD];
                pciIrq_ff[s] <= irqSync_ff[s] &
                    ~ctl_ff[s][CBR_BIT_LEGACY_IRQ];
                legacyIrq_ff[s] <= irqSync_ff[s] &
                    ctl_ff[s][CBR_BIT_LEGACY_IRQ];
                cardParityErr_ff[s] <= parityErrSeen[s] &
                    ctl_ff[s][CBR_BIT_PARITY_RESP];
            end
        end
    end

    // Error reporting toward the host bus
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pciSerr_ff <= 1'b0;
            targetAbort_ff <= 1'b0;
        end
        else
        begin
            targetAbort_ff <= mabtReport_ff & (|masterAbortSeen);
            pciSerr_ff <= serrEnable & (
                (serrSync_ff[0] & ctl_ff[0][CBR_BIT_SYSERR_FWD]) |
                (serrSync_ff[1] & ctl_ff[1][CBR_BIT_SYSERR_FWD]) |
                (mabtReport_ff & (|masterAbortSeen)));
        end
    end

    // Forwarding decision for host accesses toward a socket
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            accForward_ff <= 1'b0;
            accDone_ff <= 1'b0;
        end
        else
        begin
            accDone_ff <= accValid;
            if (accValid)
            begin
                if (accIsIo && ctl_ff[accSocket][CBR_BIT_ISA_FILTER] &&
                    accAddr < CBR_ISA_LIMIT && accAddr[9:8] != 2'h0)
                    accForward_ff <= 1'b0;
                else if (ctl_ff[accSocket][CBR_BIT_VGA_FWD] && (accIsIo ?
                    (inRange(accAddr, CBR_VGA_IO_LO0, CBR_VGA_IO_HI0) ||
                     inRange(accAddr, CBR_VGA_IO_LO1, CBR_VGA_IO_HI1)) :
                    inRange(accAddr, CBR_VGA_MEM_LO, CBR_VGA_MEM_HI)))
                    accForward_ff <= 1'b1;
                else
                    accForward_ff <= 1'b0;
            end
        end
    end

    // Checks
    property p_cardResetOnHost;
        @(posedge clk) disable iff (!resetn)
        hostRst_ff |=> (cardResetN_ff == 2'h0);
    endproperty
    a_cardResetOnHost: assert property (p_cardResetOnHost)
        else $error("card reset not asserted during host reset");

    property p_crstKept;
        @(posedge clk) disable iff (!resetn)
        hostRst_ff |=> (ctl_ff[0][CBR_BIT_CARD_RESET] ==
            $past(ctl_ff[0][CBR_BIT_CARD_RESET]));
    endproperty
    a_crstKept: assert property (p_crstKept)
        else $error("card reset bit changed by host reset");

    property p_crstDrives;
        @(posedge clk) disable iff (!resetn)
        (!hostRst_ff && !ctl_ff[1][CBR_BIT_CARD_RESET]) |=> cardResetN_ff[1];
    endproperty
    a_crstDrives: assert property (p_crstDrives)
        else $error("card reset held with bit clear");

    property p_reservedZero;
        @(posedge clk) disable iff (!resetn)
        (rdValid_ff && $past(cfg.addr[7:1]) == CBR_OFS_BRIDGE_CTL[7:1])
            |-> (rdData_ff[15:11] == 5'h00 && !rdData_ff[4]);
    endproperty
    a_reservedZero: assert property (p_reservedZero)
        else $error("reserved control bits read nonzero");

    sequence s_svidLocked;
        cfg.wr && subsysWriteEn;
    endsequence
    property p_svidLocked;
        @(posedge clk) disable iff (!resetn)
        s_svidLocked |=> $stable(svid_ff);
    endproperty
    a_svidLocked: assert property (p_svidLocked)
        else $error("vendor word written while locked");

    property p_svidRead;
        @(posedge clk) disable iff (!resetn)
        (cfg.rd && cfg.addr == CBR_OFS_SUBSYS_VENDOR) |=>
            (rdValid_ff && rdData_ff == $past(svid_ff));
    endproperty
    a_svidRead: assert property (p_svidRead)
        else $error("vendor word read mismatch");

    property p_irqRoute;
        @(posedge clk) disable iff (!resetn)
        ctl_ff[0][CBR_BIT_LEGACY_IRQ] |=> !pciIrq_ff[0];
    endproperty
    a_irqRoute: assert property (p_irqRoute)
        else $error("interrupt reached PCI in legacy routing");

    property p_isaBlock;
        @(posedge clk) disable iff (!resetn)
        (accValid && accIsIo && ctl_ff[accSocket][CBR_BIT_ISA_FILTER] &&
         accAddr < CBR_ISA_LIMIT && accAddr[9:8] != 2'h0)
            |=> (accDone_ff && !accForward_ff);
    endproperty
    a_isaBlock: assert property (p_isaBlock)
        else $error("ISA alias forwarded");

    property p_noAbortQuiet;
        @(posedge clk) disable iff (!resetn)
        !mabtReport_ff |=> !targetAbort_ff;
    endproperty
    a_noAbortQuiet: assert property (p_noAbortQuiet)
        else $error("target abort with reporting off");

    property p_parityGate;
        @(posedge clk) disable iff (!resetn)
        !ctl_ff[0][CBR_BIT_PARITY_RESP] |=> !cardParityErr_ff[0];
    endproperty
    a_parityGate: assert property (p_parityGate)
        else $error("parity error reported while disabled");
endmodule // cbr_bridge_regs

// File: logic/cbr_pkg.sv
// Package of the bridge control register block: offsets, layouts, types.
// Assumes a 16-bit configuration word port and two card sockets.
package cbr_pkg;
    // Configuration offsets, functions 0 and 1
    localparam logic [7:0] CBR_OFS_BRIDGE_CTL = 8'h3E;
    localparam logic [7:0] CBR_OFS_SUBSYS_VENDOR = 8'h40;
    // Bridge control word field positions
    localparam int CBR_BIT_POSTING = 10;
    localparam int CBR_BIT_WIN1_PF = 9;
    localparam int CBR_BIT_WIN0_PF = 8;
    localparam int CBR_BIT_LEGACY_IRQ = 7;
    localparam int CBR_BIT_CARD_RESET = 6;
    localparam int CBR_BIT_MABT_REPORT = 5;
    localparam int CBR_BIT_VGA_FWD = 3;
    localparam int CBR_BIT_ISA_FILTER = 2;
    localparam int CBR_BIT_SYSERR_FWD = 1;
    localparam int CBR_BIT_PARITY_RESP = 0;
    // Reset value and writable masks
    localparam logic [15:0] CBR_CTL_RESET = 16'h0340;
    localparam logic [15:0] CBR_CTL_SOCKET_MASK = 16'h07CF;
    localparam logic [15:0] CBR_CTL_COMMON_MASK = 16'h0020;
    // Arbitrary neutral default for the subsystem vendor word
    localparam logic [15:0] CBR_SVID_RESET = 16'h5A5A;
    // Address ranges for forwarding decisions
    localparam logic [31:0] CBR_ISA_LIMIT = 32'h0001_0000;
    localparam logic [31:0] CBR_VGA_MEM_LO = 32'h000A_0000;
    localparam logic [31:0] CBR_VGA_MEM_HI = 32'h000B_FFFF;
    localparam logic [31:0] CBR_VGA_IO_LO0 = 32'h0000_03B0;
    localparam logic [31:0] CBR_VGA_IO_HI0 = 32'h0000_03BB;
    localparam logic [31:0] CBR_VGA_IO_LO1 = 32'h0000_03C0;
    localparam logic [31:0] CBR_VGA_IO_HI1 = 32'h0000_03DF;

    // Configuration access from the host bus
    typedef struct packed {
        logic wr;
        logic rd;
        logic func;
        logic [7:0] addr;
        logic [1:0] be;
        logic [15:0] wdata;
    } cbr_cfg_s;

    // Per-socket decoded controls
    typedef struct packed {
        logic posting;
        logic win1Pf;
        logic win0Pf;
        logic vgaFwd;
    } cbr_sock_s;
endpackage

// File: tb/cbr_bridge_regs_tb.sv
// Testbench of the bridge control register block.
// Assumes the card model and the design package are compiled first.
`timescale 1ns/1ps
module cbr_bridge_regs_tb;
    import cbr_pkg::*;
    logic clk, resetn, hostBusResetN, subsysWriteEn, serrEnable;
    cbr_cfg_s cfg;
    logic [1:0] cardIrqIn, cardSysErrIn, parityErrSeen, masterAbortSeen;
    logic accValid, accSocket, accIsIo, rdValid_ff, pciSerr_ff;
    logic [31:0] accAddr;
    logic [15:0] rdData_ff;
    logic [1:0] cardResetN_ff, pciIrq_ff, legacyIrq_ff, cardParityErr_ff;
    cbr_sock_s [1:0] sockCtl_ff;
    logic targetAbort_ff, accForward_ff, accDone_ff;
    int mismatches, nCompared;

    cbr_bridge_regs i_cbr_bridge_regs (.clk(clk), .resetn(resetn),
        .hostBusResetN(hostBusResetN), .cfg(cfg),
        .subsysWriteEn(subsysWriteEn), .serrEnable(serrEnable),
        .cardIrqIn(cardIrqIn), .cardSysErrIn(cardSysErrIn),
        .parityErrSeen(parityErrSeen), .masterAbortSeen(masterAbortSeen),
        .accValid(accValid), .accSocket(accSocket), .accIsIo(accIsIo),
        .accAddr(accAddr), .rdData_ff(rdData_ff), .rdValid_ff(rdValid_ff),
        .cardResetN_ff(cardResetN_ff), .sockCtl_ff(sockCtl_ff),
        .pciIrq_ff(pciIrq_ff), .legacyIrq_ff(legacyIrq_ff),
        .pciSerr_ff(pciSerr_ff), .targetAbort_ff(targetAbort_ff),
        .cardParityErr_ff(cardParityErr_ff),
        .accForward_ff(accForward_ff), .accDone_ff(accDone_ff));

    cbr_card_model i_cbr_card_model (.clk(clk), .cardResetN(cardResetN_ff),
        .cardIrqIn(cardIrqIn), .cardSysErrIn(cardSysErrIn),
        .parityErrSeen(parityErrSeen), .masterAbortSeen(masterAbortSeen));

    // 50 MHz clock
    always #10 clk = ~clk;

    // Compare and count
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Advance n edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Configuration word write, both lanes
    task automatic cfgWr(input logic f, input logic [7:0] a,
                         input logic [15:0] d);
        tick(1);
        cfg = '{wr: 1'b1, rd: 1'b0, func: f, addr: a, be: 2'h3, wdata: d};
        tick(1);
        cfg.wr = 1'b0;
    endtask

    // Configuration word read with bounded wait for the answer
    task automatic cfgRd(input logic f, input logic [7:0] a,
                         input logic [15:0] exp);
        logic hit;
        hit = 1'b0;
        tick(1);
        cfg = '{wr: 1'b0, rd: 1'b1, func: f, addr: a, be: 2'h3, wdata: 16'h0};
        for (int i = 0; i < 4 && !hit; i++)
        begin
            tick(1);
            cfg.rd = 1'b0;
            hit = (rdValid_ff === 1'b1);
        end
        chk("read answer", {31'h0, hit}, 32'h1);
        chk("read data", {16'h0, rdData_ff}, {16'h0, exp});
    endtask

    // Forwarding query
    task automatic acc(input logic s, input logic io, input logic [31:0] ad,
                       input logic exp);
        tick(1);
        accValid = 1'b1;
        accSocket = s;
        accIsIo = io;
        accAddr = ad;
        tick(1);
        accValid = 1'b0;
        chk("query done", {31'h0, accDone_ff}, 32'h1);
        chk("forward", {31'h0, accForward_ff}, {31'h0, exp});
    endtask

    // Verdict and end of run
    task automatic print_verdict();
        if (mismatches == 0 && nCompared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        clk = 1'b0;
        resetn = 1'b0;
        hostBusResetN = 1'b1;
        subsysWriteEn = 1'b1;
        serrEnable = 1'b0;
        cfg = '0;
        accValid = 1'b0;
        accSocket = 1'b0;
        accIsIo = 1'b0;
        accAddr = 32'h0;
        mismatches = 0;
        nCompared = 0;
        tick(8);
        resetn = 1'b1;
        chk("card reset", {30'h0, cardResetN_ff}, 32'h0);
        cfgRd(1'b0, 8'h3E, 16'h0340);
        cfgRd(1'b1, 8'h3E, 16'h0340);
        cfgRd(1'b0, 8'h40, CBR_SVID_RESET);
        cfgRd(1'b0, 8'h50, 16'h0000);
        cfgWr(1'b0, 8'h3E, 16'hFFFF);
        cfgRd(1'b0, 8'h3E, 16'h07EF);
        cfgRd(1'b1, 8'h3E, 16'h0360);
        chk("socket0 ctl", {28'h0, sockCtl_ff[0]}, 32'hF);
        chk("socket1 ctl", {28'h0, sockCtl_ff[1]}, 32'h6);
        cfgWr(1'b0, 8'h3E, 16'h002F);
        tick(2);
        chk("card reset", {30'h0, cardResetN_ff}, 32'h1);
        acc(1'b0, 1'b0, 32'h000A_0000, 1'b1);
        acc(1'b1, 1'b0, 32'h000A_0000, 1'b0);
        acc(1'b0, 1'b1, 32'h0000_03C0, 1'b0);
        serrEnable = 1'b1;
        i_cbr_card_model.setPins(2'h3, 2'h1, 2'h3);
        tick(5);
        chk("pci irq", {30'h0, pciIrq_ff}, 32'h1);
        chk("serr", {31'h0, pciSerr_ff}, 32'h1);
        chk("parity", {30'h0, cardParityErr_ff}, 32'h1);
        i_cbr_card_model.pulseAbort(2'h1);
        chk("target abort", {31'h0, targetAbort_ff}, 32'h1);
        cfgWr(1'b0, 8'h3E, 16'h0088);
        tick(5);
        chk("legacy irq", {30'h0, legacyIrq_ff}, 32'h1);
        chk("pci irq off", {30'h0, pciIrq_ff}, 32'h0);
        chk("serr off", {31'h0, pciSerr_ff}, 32'h0);
        chk("parity off", {30'h0, cardParityErr_ff}, 32'h0);
        acc(1'b0, 1'b1, 32'h0000_03C0, 1'b1);
        i_cbr_card_model.pulseAbort(2'h1);
        chk("abort off", {31'h0, targetAbort_ff}, 32'h0);
        i_cbr_card_model.setPins(2'h0, 2'h0, 2'h0);
        hostBusResetN = 1'b0;
        tick(4);
        chk("host reset", {30'h0, cardResetN_ff}, 32'h0);
        cfgWr(1'b0, 8'h3E, 16'hFFFF);
        cfgRd(1'b0, 8'h3E, 16'h0300);
        hostBusResetN = 1'b1;
        tick(4);
        chk("card reset kept", {30'h0, cardResetN_ff}, 32'h1);
        cfgWr(1'b0, 8'h40, 16'h1234);
        cfgRd(1'b1, 8'h40, CBR_SVID_RESET);
        subsysWriteEn = 1'b0;
        cfgWr(1'b1, 8'h40, 16'h1234);
        cfgRd(1'b0, 8'h40, 16'h1234);
        cfgWr(1'b1, 8'h3E, 16'h0300);
        tick(2);
        chk("card reset both", {30'h0, cardResetN_ff}, 32'h3);
        print_verdict();
    end
endmodule // cbr_bridge_regs_tb

// File: tb/cbr_card_model.sv
// Card socket model: drives the card-side pins of both sockets.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
module cbr_card_model
(
    input wire logic clk,
    input wire logic [1:0] cardResetN,
    output logic [1:0] cardIrqIn,
    output logic [1:0] cardSysErrIn,
    output logic [1:0] parityErrSeen,
    output logic [1:0] masterAbortSeen
);
    logic [1:0] irqReq;
    logic [1:0] serrReq;

    // A card held in reset raises no interrupt or system error
    assign cardIrqIn = irqReq & cardResetN;
    assign cardSysErrIn = serrReq & cardResetN;

    // Quiet pins at time zero
    initial
    begin
        irqReq = 2'h0;
        serrReq = 2'h0;
        parityErrSeen = 2'h0;
        masterAbortSeen = 2'h0;
    end

    // Pin levels requested by the bench
    task automatic setPins(input logic [1:0] irq, input logic [1:0] serr,
                           input logic [1:0] par);
        irqReq = irq;
        serrReq = serr;
        parityErrSeen = par;
    endtask

    // One-cycle master abort pulse
    task automatic pulseAbort(input logic [1:0] s);
        masterAbortSeen = s;
        @(posedge clk);
        #1;
        masterAbortSeen = 2'h0;
    endtask
endmodule // cbr_card_model
